// *** rtl/jtd_pkg.sv ***
package jtd_pkg;

  // Instruction register
  localparam int IR_W = 3;
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLE = 3'h2;
  localparam logic [2:0] INS_CLAMP = 3'h3;
  localparam logic [2:0] INS_HIGHZ = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;

  // Identification code fields, values arbitrary
  localparam int ID_W = 32;
  localparam logic [3:0] ID_VERSION = 4'h0;
  localparam logic [15:0] ID_DEVICE = 16'h0a5c;
  localparam logic [10:0] ID_MAKER = 11'h155;
  localparam logic ID_LSB = 1'h1;

  // Boundary chain
  localparam int BSR_W = 46;
  // Cells that are three-state outputs
  localparam logic [45:0] BSR_OUT3 = 46'h3f00_0200_4005;

  function automatic int ctrl_cell(input int i);
    case (i)
      2: ctrl_cell = 3;
      14: ctrl_cell = 15;
      25: ctrl_cell = 26;
      default: ctrl_cell = 1;
    endcase
  endfunction

  // Test access pins, sampled together
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jtd_pins_s;

  typedef enum logic [3:0] {
    TLR = 4'h0,
    RTI = 4'h1,
    SEL_DR = 4'h3,
    CAP_DR = 4'h2,
    SH_DR = 4'h6,
    EX1_DR = 4'h7,
    PA_DR = 4'h5,
    EX2_DR = 4'h4,
    UPD_DR = 4'hc,
    SEL_IR = 4'hd,
    CAP_IR = 4'hf,
    SH_IR = 4'he,
    EX1_IR = 4'ha,
    PA_IR = 4'hb,
    EX2_IR = 4'h9,
    UPD_IR = 4'h8
  } jtd_tap_e;

endpackage

// *** rtl/jtd_shreg.sv ***
`timescale 1ns/1ns
`default_nettype none
module jtd_shreg #(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  input wire logic init,
  input wire logic [W-1:0] cap_data,
  input wire logic sin,
  output logic [W-1:0] sh_q,
  output logic [W-1:0] par_q
);

  logic [W-1:0] nxt_sh;

  // Shift toward bit 0, new bit enters at the top
  generate
    if (W == 1)
    begin : g_one
      assign nxt_sh = sin;
    end
    else
    begin : g_many
      assign nxt_sh = {sin, sh_q[W-1:1]};
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_q <= '0;
      par_q <= INIT;
    end
    else if (ce)
    begin
      if (capture)
        sh_q <= cap_data;
      else if (shift)
        sh_q <= nxt_sh;
      if (init)
        par_q <= INIT;
      else if (update)
        par_q <= sh_q;
    end
  end

endmodule
`default_nettype wire

// *** rtl/jtd_test_data_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
module jtd_test_data_regs #(
  parameter int BSR_W = jtd_pkg::BSR_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic test_clock_in,
  input wire logic test_mode_select,
  input wire logic test_serial_in,
  input wire logic test_reset_n,
  input wire logic [BSR_W-1:0] sys_pin_in,
  input wire logic [BSR_W-1:0] sys_out,
  input wire logic [BSR_W-1:0] sys_oe,
  output logic test_serial_out,
  output logic test_serial_out_oe,
  output logic [BSR_W-1:0] pin_out,
  output logic [BSR_W-1:0] pin_oe
);

  generate
    if (BSR_W != jtd_pkg::BSR_W)
    begin : g_chk
      $error("Boundary length must match the cell map");
    end
  endgenerate

  jtd_pkg::jtd_pins_s pins_in;
  jtd_pkg::jtd_pins_s sync1_ff;
  jtd_pkg::jtd_pins_s sync2_ff;
  logic tck_prev_ff;
  jtd_pkg::jtd_tap_e tap_ff;
  jtd_pkg::jtd_tap_e nxt_tap;
  logic tdo_ff;
  logic tdo_oe_ff;
  logic [BSR_W-1:0] pin_out_ff;
  logic [BSR_W-1:0] pin_oe_ff;

  assign pins_in.tck = test_clock_in;
  assign pins_in.tms = test_mode_select;
  assign pins_in.tdi = test_serial_in;
  assign pins_in.trst_n = test_reset_n;

  // Two-stage sampling of the test pins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Test clock idles high, so no false edge after reset
      sync1_ff <= '{tck: 1'h1, tms: 1'h1, tdi: 1'h1, trst_n: 1'h0};
      sync2_ff <= '{tck: 1'h1, tms: 1'h1, tdi: 1'h1, trst_n: 1'h0};
      tck_prev_ff <= 1'h1;
    end
    else if (ce)
    begin
      sync1_ff <= pins_in;
      sync2_ff <= sync1_ff;
      tck_prev_ff <= sync2_ff.tck;
    end
  end

  wire tck_rise = sync2_ff.tck & ~tck_prev_ff;
  wire tck_fall = ~sync2_ff.tck & tck_prev_ff;
  wire tms = sync2_ff.tms;
  wire tdi = sync2_ff.tdi;

  // Controller next state
  always_comb
  begin
    case (tap_ff)
      jtd_pkg::TLR: nxt_tap = tms ? jtd_pkg::TLR : jtd_pkg::RTI;
      jtd_pkg::RTI: nxt_tap = tms ? jtd_pkg::SEL_DR : jtd_pkg::RTI;
      jtd_pkg::SEL_DR: nxt_tap = tms ? jtd_pkg::SEL_IR : jtd_pkg::CAP_DR;
      jtd_pkg::CAP_DR: nxt_tap = tms ? jtd_pkg::EX1_DR : jtd_pkg::SH_DR;
      jtd_pkg::SH_DR: nxt_tap = tms ? jtd_pkg::EX1_DR : jtd_pkg::SH_DR;
      jtd_pkg::EX1_DR: nxt_tap = tms ? jtd_pkg::UPD_DR : jtd_pkg::PA_DR;
      jtd_pkg::PA_DR: nxt_tap = tms ? jtd_pkg::EX2_DR : jtd_pkg::PA_DR;
      jtd_pkg::EX2_DR: nxt_tap = tms ? jtd_pkg::UPD_DR : jtd_pkg::SH_DR;
      jtd_pkg::UPD_DR: nxt_tap = tms ? jtd_pkg::SEL_DR : jtd_pkg::RTI;
      jtd_pkg::SEL_IR: nxt_tap = tms ? jtd_pkg::TLR : jtd_pkg::CAP_IR;
      jtd_pkg::CAP_IR: nxt_tap = tms ? jtd_pkg::EX1_IR : jtd_pkg::SH_IR;
      jtd_pkg::SH_IR: nxt_tap = tms ? jtd_pkg::EX1_IR : jtd_pkg::SH_IR;
      jtd_pkg::EX1_IR: nxt_tap = tms ? jtd_pkg::UPD_IR : jtd_pkg::PA_IR;
      jtd_pkg::PA_IR: nxt_tap = tms ? jtd_pkg::EX2_IR : jtd_pkg::PA_IR;
      jtd_pkg::EX2_IR: nxt_tap = tms ? jtd_pkg::UPD_IR : jtd_pkg::SH_IR;
      jtd_pkg::UPD_IR: nxt_tap = tms ? jtd_pkg::SEL_DR : jtd_pkg::RTI;
      default: nxt_tap = jtd_pkg::TLR;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tap_ff <= jtd_pkg::TLR;
    else if (ce)
    begin
      if (!sync2_ff.trst_n)
        tap_ff <= jtd_pkg::TLR;
      else if (tck_rise)
        tap_ff <= nxt_tap;
    end
  end

  wire in_tlr = (tap_ff == jtd_pkg::TLR);
  wire cap_dr = tck_rise & (tap_ff == jtd_pkg::CAP_DR);
  wire sh_dr = tck_rise & (tap_ff == jtd_pkg::SH_DR);
  wire upd_dr = tck_fall & (tap_ff == jtd_pkg::UPD_DR);
  wire cap_ir = tck_rise & (tap_ff == jtd_pkg::CAP_IR);
  wire sh_ir = tck_rise & (tap_ff == jtd_pkg::SH_IR);
  wire upd_ir = tck_fall & (tap_ff == jtd_pkg::UPD_IR);

  logic [jtd_pkg::IR_W-1:0] ir_sh;
  logic [jtd_pkg::IR_W-1:0] ir_cur;

  // Reset state forces the id instruction
  jtd_shreg #(.W(jtd_pkg::IR_W), .INIT(jtd_pkg::INS_IDCODE)) u_ir (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .capture(cap_ir),
    .shift(sh_ir),
    .update(upd_ir),
    .init(in_tlr),
    .cap_data(jtd_pkg::IR_CAPTURE),
    .sin(tdi),
    .sh_q(ir_sh),
    .par_q(ir_cur)
  );

  // Id selected by instruction or reset state
  wire sel_id = (ir_cur == jtd_pkg::INS_IDCODE) | in_tlr;
  wire sel_bsr = ~in_tlr & ((ir_cur == jtd_pkg::INS_EXTEST) |
                            (ir_cur == jtd_pkg::INS_SAMPLE));
  wire sel_byp = ~sel_id & ~sel_bsr;
  wire drive_bsr = (ir_cur == jtd_pkg::INS_EXTEST) |
                   (ir_cur == jtd_pkg::INS_CLAMP);
  wire force_hz = (ir_cur == jtd_pkg::INS_HIGHZ);

  wire [jtd_pkg::ID_W-1:0] id_code = {jtd_pkg::ID_VERSION,
                                      jtd_pkg::ID_DEVICE,
                                      jtd_pkg::ID_MAKER,
                                      jtd_pkg::ID_LSB};
  logic [jtd_pkg::ID_W-1:0] id_sh;
  logic [BSR_W-1:0] bsr_sh;
  logic [BSR_W-1:0] bsr_par;
  logic byp_sh;

  jtd_shreg #(.W(jtd_pkg::ID_W), .INIT('0)) u_id (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .capture(cap_dr & sel_id),
    .shift(sh_dr & sel_id),
    .update(upd_dr & sel_id),
    .init(1'h0),
    .cap_data(id_code),
    .sin(tdi),
    .sh_q(id_sh),
    .par_q()
  );

  jtd_shreg #(.W(BSR_W), .INIT('0)) u_bsr (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .capture(cap_dr & sel_bsr),
    .shift(sh_dr & sel_bsr),
    .update(upd_dr & sel_bsr),
    .init(1'h0),
    .cap_data(sys_pin_in),
    .sin(tdi),
    .sh_q(bsr_sh),
    .par_q(bsr_par)
  );

  jtd_shreg #(.W(1), .INIT(1'h0)) u_byp (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .capture(cap_dr & sel_byp),
    .shift(sh_dr & sel_byp),
    .update(1'h0),
    .init(1'h0),
    .cap_data(1'h0),
    .sin(tdi),
    .sh_q(byp_sh),
    .par_q()
  );

  wire in_sh_ir = (tap_ff == jtd_pkg::SH_IR);
  wire in_sh_dr = (tap_ff == jtd_pkg::SH_DR);
  wire dr_bit = sel_id ? id_sh[0] : (sel_bsr ? bsr_sh[0] : byp_sh);
  wire nxt_tdo = in_sh_ir ? ir_sh[0] : dr_bit;

  // Serial out changes on the falling test clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdo_ff <= 1'h0;
      tdo_oe_ff <= 1'h0;
    end
    else if (ce && tck_fall)
    begin
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= in_sh_ir | in_sh_dr;
    end
  end

  // Output enable from paired control cell under EXTEST and CLAMP, else from sys_oe, and off under HIGHZ
  logic [BSR_W-1:0] nxt_pin_out;
  logic [BSR_W-1:0] nxt_pin_oe;
  genvar gi;
  generate
    for (gi = 0; gi < BSR_W; gi++)
    begin : g_cell
      localparam int CC = jtd_pkg::ctrl_cell(gi);
      wire is_out = jtd_pkg::BSR_OUT3[gi];
      wire test_oe = is_out & bsr_par[CC];
      assign nxt_pin_out[gi] = drive_bsr ? bsr_par[gi] : sys_out[gi];
      assign nxt_pin_oe[gi] = force_hz ? 1'h0 :
                              (drive_bsr ? test_oe : (is_out & sys_oe[gi]));
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
    end
    else if (ce)
    begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign test_serial_out = tdo_ff;
  assign test_serial_out_oe = tdo_oe_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;

endmodule
`default_nettype wire

// *** tb/jtd_checker_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module jtd_checker #(
  parameter int BSR_W = 46
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic test_clock_in,
  input wire logic test_reset_n,
  input wire logic [BSR_W-1:0] sys_out,
  input wire logic [BSR_W-1:0] sys_oe,
  input wire logic test_serial_out,
  input wire logic test_serial_out_oe,
  input wire logic [BSR_W-1:0] pin_out,
  input wire logic [BSR_W-1:0] pin_oe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [BSR_W-1:0] out3;
  assign out3 = jtd_pkg::BSR_OUT3;
  tri_only_a: assert property (
    (pin_oe & ~out3) == '0) else $error("enable on input cell");
  rst_clear_a: assert property (
    $rose(rst_n) |-> !test_serial_out_oe && pin_oe == '0)
    else $error("outputs not clear after reset");
  rst_pins_a: assert property (
    $rose(rst_n) |-> ##2 pin_out == $past(sys_out)
    && pin_oe == ($past(sys_oe) & out3)) else $error("pins not normal");
  tdo_fall_a: assert property (
    $changed({test_serial_out, test_serial_out_oe})
    |-> !$past(test_clock_in, 3)) else $error("serial out off fall");
  tdo_hold_a: assert property (
    $rose(test_clock_in) |-> ##2 $stable(test_serial_out)[*3])
    else $error("serial out moved while clock high");
  oe_min_a: assert property (
    $rose(test_serial_out_oe) |=> test_serial_out_oe[*5])
    else $error("serial enable too short");
  trst_pins_a: assert property (
    (!test_reset_n)[*6] |=> pin_out == $past(sys_out)
    && pin_oe == ($past(sys_oe) & out3)) else $error("test reset pins");
  trst_quiet_a: assert property (
    (!test_reset_n)[*6] |=> !test_serial_out_oe)
    else $error("serial enable in test reset");
endmodule
bind jtd_test_data_regs jtd_checker #(.BSR_W(BSR_W)) i_chk (
  .clk(clk), .rst_n(rst_n), .test_clock_in(test_clock_in),
  .test_reset_n(test_reset_n), .sys_out(sys_out), .sys_oe(sys_oe),
  .test_serial_out(test_serial_out),
  .test_serial_out_oe(test_serial_out_oe),
  .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// *** tb/jtd_tester.sv ***
`timescale 1ns/1ns
`default_nettype none
module jtd_tester (
  input wire logic clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo
);
  initial
  begin
    tck = 1'h1;
    tms = 1'h1;
    tdi = 1'h0;
    trst_n = 1'h1;
  end
  // One test clock period, serial out sampled late in the high phase
  task automatic tick(input logic m, input logic d, output logic q);
    @(posedge clk);
    #1;
    tck = 1'h0;
    tms = m;
    tdi = d;
    #32;
    tck = 1'h1;
    #30;
    q = tdo;
  endtask
  task automatic hold_reset();
    @(posedge clk);
    #1;
    trst_n = 1'h0;
    repeat (10) @(posedge clk);
    #1;
    trst_n = 1'h1;
  endtask
endmodule
`default_nettype wire

// *** tb/jtag_test_data_registers_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module jtag_test_data_registers_bench;
  localparam logic [45:0] PIN_IN = 46'h1234_5678_9abc;
  localparam logic [45:0] PAT = 46'h2c3a_5a5a_c3c3;
  localparam logic [63:0] ID = {32'h0, jtd_pkg::ID_VERSION,
    jtd_pkg::ID_DEVICE, jtd_pkg::ID_MAKER, jtd_pkg::ID_LSB};
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [45:0] sys_out = 46'h0f0f_3333_5555;
  logic [45:0] sys_oe = 46'h3fff_ffff_ffff;
  logic [45:0] pin_out, pin_oe, eoe;
  logic [63:0] q;
  int bad_count = 0;
  int num_checks = 0;
  always #4 clk = ~clk;
  jtd_test_data_regs i_dut (.clk(clk), .rst_n(rst_n), .ce(1'h1),
    .test_clock_in(tck), .test_mode_select(tms), .test_serial_in(tdi),
    .test_reset_n(trst_n), .sys_pin_in(PIN_IN), .sys_out(sys_out),
    .sys_oe(sys_oe), .test_serial_out(tdo), .test_serial_out_oe(tdo_oe),
    .pin_out(pin_out), .pin_oe(pin_oe));
  jtd_tester i_tst (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo));
  task automatic chk(input string nm, input logic [63:0] e,
    input logic [63:0] s);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // From idle: one IR or DR scan of n bits, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] d);
    logic b;
    i_tst.tick(1'h1, 1'h0, b);
    if (ir)
      i_tst.tick(1'h1, 1'h0, b);
    i_tst.tick(1'h0, 1'h0, b);
    i_tst.tick(1'h0, 1'h0, b);
    q = 64'h0;
    for (int i = 0; i < n; i++)
    begin
      i_tst.tick(i == n - 1, d[i], b);
      q[i] = b;
      if (i == 0)
        chk("shift oe on", 64'h1, {63'h0, tdo_oe});
    end
    i_tst.tick(1'h1, 1'h0, b);
    i_tst.tick(1'h0, 1'h0, b);
    repeat (8) @(posedge clk);
    chk("shift oe off", 64'h0, {63'h0, tdo_oe});
  endtask
  task automatic t_id();
    logic b;
    i_tst.tick(1'h0, 1'h0, b);
    scan(1'h0, 32, 64'h0);
    chk("idcode", ID, q);
    chk("id lsb", 64'h1, {63'h0, q[0]});
    $display("idcode test done");
  endtask
  task automatic t_ir();
    logic [2:0] ins[4] = '{jtd_pkg::INS_CLAMP, jtd_pkg::INS_HIGHZ,
      jtd_pkg::INS_BYPASS, 3'h5};
    foreach (ins[k])
    begin
      scan(1'h1, 3, {61'h0, ins[k]});
      chk("ir capture", {61'h0, jtd_pkg::IR_CAPTURE}, q);
      scan(1'h0, 4, 64'h6);
      chk("bypass", 64'hc, q);
    end
    scan(1'h1, 3, {61'h0, jtd_pkg::INS_IDCODE});
    scan(1'h0, 32, 64'h0);
    chk("id selected", ID, q);
    $display("instruction test done");
  endtask
  task automatic t_bsr();
    int c;
    scan(1'h1, 3, {61'h0, jtd_pkg::INS_SAMPLE});
    scan(1'h0, 46, {18'h0, PAT});
    chk("boundary capture", {18'h0, PIN_IN}, q);
    chk("sample pins", {18'h0, sys_out}, {18'h0, pin_out});
    chk("sample oe", {18'h0, sys_oe & jtd_pkg::BSR_OUT3},
      {18'h0, pin_oe});
    for (int i = 0; i < 46; i++)
    begin
      c = i == 2 ? 3 : i == 14 ? 15 : i == 25 ? 26 : 1;
      eoe[i] = jtd_pkg::BSR_OUT3[i] & PAT[c];
    end
    scan(1'h1, 3, {61'h0, jtd_pkg::INS_EXTEST});
    chk("extest out", {18'h0, PAT}, {18'h0, pin_out});
    chk("extest oe", {18'h0, eoe}, {18'h0, pin_oe});
    scan(1'h1, 3, {61'h0, jtd_pkg::INS_HIGHZ});
    chk("highz oe", 64'h0, {18'h0, pin_oe});
    scan(1'h1, 3, {61'h0, jtd_pkg::INS_CLAMP});
    chk("clamp out", {18'h0, PAT}, {18'h0, pin_out});
    chk("clamp oe", {18'h0, eoe}, {18'h0, pin_oe});
    $display("boundary test done");
  endtask
  task automatic t_rst();
    i_tst.hold_reset();
    repeat (4) @(posedge clk);
    chk("reset pins", {18'h0, sys_out}, {18'h0, pin_out});
    t_id();
    $display("test reset done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    bad_count++;
    results();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'h1;
    repeat (4) @(posedge clk);
    t_id();
    t_ir();
    t_bsr();
    t_rst();
    results();
  end
endmodule
`default_nettype wire
